// >>> hdl/cam_addr_unit.v
// Purpose: Operand addressing unit of an 8-bit core: length, pointers, effective address.
// Assumes: Opcode, mode and memory data arrive from the fetch logic on i_clk.
// Notes:   Memory answers within the cycle in which o_mem_rd stands; data is taken at its end.
// Operation
// - Short direct and indirect forms reach page zero only; short indexed forms reach up to 1FE; long forms reach the full 64 Kbyte space.
// - Read-modify-write memory operations are flagged illegal in the three long addressing forms.
// - Inherent instructions are one byte, no operand bytes fetched.
// - Immediate instructions take one operand byte used directly as value.
// - Short direct fetches one address byte, zero-page operand.
// - Long direct fetches a two-byte address word.
// - Indexed address is unsigned index register plus offset.
// - Indexed without offset uses the index register alone.
// - Short indexed adds one-byte offset, up to 1FE.
// - Long indexed adds index to a two-byte offset word.
// - Indirect modes read operand address at zero-page pointer after opcode.
// - Short indirect reads a one-byte pointer, operands in page zero.
// - Long indirect reads a two-byte pointer word from page zero.
// - Indirect indexed adds index register to fetched pointer value.
// - Short indirect indexed: byte pointer plus index, up to 1FE.
// - Mask set sets level 3; mask clear sets level 0.
// - Halt stops oscillator; wait-for-interrupt idles until an interrupt.
// - Relative target is program counter plus 2 plus signed 8-bit offset.
// - Prefix 90 swaps first index register for second one.
`timescale 1ns/1ps
`include "cam_map.vh"

module cam_addr_unit (
    input  wire        i_clk,
    input  wire        i_reset,
    input  wire        i_start,
    input  wire [7:0]  i_prefix,
    input  wire [3:0]  i_mode,
    input  wire        i_rmw,
    input  wire        i_mask_irq_set_op,
    input  wire        i_mask_irq_clear_op,
    input  wire        i_halt_op,
    input  wire        i_wait_for_irq_op,
    input  wire        i_irq,
    input  wire [15:0] i_pc,
    input  wire [7:0]  i_idx_x,
    input  wire [7:0]  i_idx_y,
    input  wire [7:0]  i_mem_data,
    output wire        o_mem_rd,
    output reg  [15:0] o_mem_addr,
    output reg  [15:0] o_ea,
    output reg  [7:0]  o_imm,
    output reg         o_done,
    output reg         o_illegal,
    output reg  [15:0] o_pc_next,
    output reg  [1:0]  o_irq_mask,
    output reg         o_osc_stop,
    output reg         o_wait_state
);

    // Sequencer states.
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_OP1  = 3'h1;
    localparam [2:0] ST_OP2  = 3'h2;
    localparam [2:0] ST_PT1  = 3'h3;
    localparam [2:0] ST_PT2  = 3'h4;
    localparam [2:0] ST_FIN  = 3'h5;

    reg  [2:0]  state_reg;
    reg  [2:0]  state_next;
    reg  [3:0]  mode_reg;
    reg  [7:0]  index_reg;
    reg  [15:0] word_reg;
    reg  [15:0] pc_reg;
    reg         rd_req;
    reg         irq_meta_reg;
    reg         irq_sync_reg;
    reg         irq_hist_reg;
    wire        irq_wake;

    // Operand byte count following the opcode for a mode.
    function [1:0] op_bytes;
        input [3:0] mode;
        begin
            case (mode)
                `CAM_MODE_INH:   op_bytes = 2'h0;
                `CAM_MODE_IDX_0: op_bytes = 2'h0;
                `CAM_MODE_DIR_L: op_bytes = 2'h2;
                `CAM_MODE_IDX_L: op_bytes = 2'h2;
                default:         op_bytes = 2'h1;
            endcase
        end
    endfunction

    // Unsigned sum of index and base, cut to the 16-bit space.
    // unsigned index addition.
    function [15:0] idx_add;
        input [7:0]  idx;
        input [15:0] base;
        begin
            idx_add = base + {8'h00, idx};
        end
    endfunction

    // True for the long modes: long direct, long indexed and long indirect.
    function is_long;
        input [3:0] mode;
        begin
            is_long = (mode == `CAM_MODE_DIR_L) || (mode == `CAM_MODE_IDX_L) ||
                      (mode == `CAM_MODE_IND_L);
        end
    endfunction

    // True for modes that read a pointer from page zero.
    function is_pointer;
        input [3:0] mode;
        begin
            is_pointer = (mode == `CAM_MODE_IND_S) || (mode == `CAM_MODE_IND_L) ||
                         (mode == `CAM_MODE_IIX_S);
        end
    endfunction

    // Next pointer byte address; a pointer word wraps inside page zero.
    function [15:0] zp_next;
        input [15:0] addr;
        begin
            zp_next = {8'h00, addr[7:0] + 8'h01};
        end
    endfunction

    assign o_mem_rd = rd_req;

    // Next-state logic of the operand sequencer.
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (i_start) begin
                    if (op_bytes(i_mode) == 2'h0)
                        state_next = ST_FIN;
                    else
                        state_next = ST_OP1;
                end
            end
            ST_OP1: begin
                if (op_bytes(mode_reg) == 2'h2)
                    state_next = ST_OP2;
                else if (is_pointer(mode_reg))
                    state_next = ST_PT1;
                else
                    state_next = ST_FIN;
            end
            ST_OP2:  state_next = ST_FIN;
            ST_PT1: begin
                if (mode_reg == `CAM_MODE_IND_L)
                    state_next = ST_PT2;
                else
                    state_next = ST_FIN;
            end
            ST_PT2:  state_next = ST_FIN;
            ST_FIN:  state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    // Memory read requests for operand and pointer bytes.
    always @* begin
        rd_req = 1'b0;
        case (state_reg)
            ST_OP1:  rd_req = 1'b1;
            ST_OP2:  rd_req = 1'b1;
            ST_PT1:  rd_req = 1'b1;
            ST_PT2:  rd_req = 1'b1;
            default: rd_req = 1'b0;
        endcase
    end

    // Sequencer state and the mode, index and program counter of the decode
    // in progress; a start that arrives while busy is ignored.
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state_reg <= ST_IDLE;
            mode_reg  <= 4'h0;
            index_reg <= 8'h00;
            pc_reg    <= 16'h0000;
            o_illegal <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (state_reg == ST_IDLE && i_start) begin
                mode_reg <= i_mode;
                pc_reg   <= i_pc;
                if (i_prefix == `CAM_PFX_SECOND)
                    index_reg <= i_idx_y;
                else
                    index_reg <= i_idx_x;
                o_illegal <= i_rmw && is_long(i_mode);
            end
        end
    end

    // Operand and pointer bytes: the address of the next read and the word
    // assembled from the bytes that memory returns at the end of each cycle.
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            word_reg   <= 16'h0000;
            o_mem_addr <= 16'h0000;
            o_imm      <= 8'h00;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    // The first operand byte follows the opcode.
                    if (i_start) begin
                        word_reg   <= 16'h0000;
                        o_mem_addr <= i_pc + 16'h0001;
                    end
                end
                ST_OP1: begin
                    o_imm    <= i_mem_data;
                    word_reg <= {8'h00, i_mem_data};
                    // Two-byte operands step on, pointer modes read at the byte.
                    if (op_bytes(mode_reg) == 2'h2)
                        o_mem_addr <= o_mem_addr + 16'h0001;
                    else
                        o_mem_addr <= {8'h00, i_mem_data};
                end
                ST_OP2: begin
                    word_reg <= {word_reg[7:0], i_mem_data};
                end
                ST_PT1: begin
                    // byte pointer read at zero page.
                    word_reg   <= {8'h00, i_mem_data};
                    o_mem_addr <= zp_next(o_mem_addr);
                end
                ST_PT2: begin
                    word_reg <= {word_reg[7:0], i_mem_data};
                end
                default: begin
                    word_reg <= word_reg;
                end
            endcase
        end
    end

    // Result registers: done pulse, next program counter and effective address,
    // loaded in the closing state and held until the next decode ends.
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_done    <= 1'b0;
            o_pc_next <= 16'h0000;
            o_ea      <= 16'h0000;
        end else begin
            o_done <= (state_reg == ST_FIN);
            if (state_reg == ST_FIN) begin
                o_pc_next <= pc_reg + 16'h0001 + {14'h0000, op_bytes(mode_reg)};
                case (mode_reg)
                    `CAM_MODE_DIR_S: o_ea <= word_reg & `CAM_ZP_TOP;
                    `CAM_MODE_DIR_L: o_ea <= word_reg;
                    `CAM_MODE_IDX_0: o_ea <= {8'h00, index_reg};
                    `CAM_MODE_IDX_S: o_ea <= idx_add(index_reg, word_reg);
                    `CAM_MODE_IDX_L: o_ea <= idx_add(index_reg, word_reg);
                    `CAM_MODE_IND_S: o_ea <= word_reg & `CAM_ZP_TOP;
                    `CAM_MODE_IND_L: o_ea <= word_reg;
                    `CAM_MODE_IIX_S: o_ea <= idx_add(index_reg, word_reg);
                    `CAM_MODE_REL:   o_ea <= pc_reg + 16'h0002 +
                                             {{8{word_reg[7]}}, word_reg[7:0]};
                    default:         o_ea <= 16'h0000;
                endcase
            end
        end
    end

    // Interrupt mask level; set wins when both strobes arrive together.
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_irq_mask <= `CAM_MASK_HIGH;
        end else begin
            if (i_mask_irq_set_op)
                o_irq_mask <= `CAM_MASK_HIGH;
            else if (i_mask_irq_clear_op)
                o_irq_mask <= `CAM_MASK_LOW;
        end
    end

    // Wake request synchroniser; the request may change while the clock is stopped.
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            irq_meta_reg <= 1'b0;
            irq_sync_reg <= 1'b0;
            irq_hist_reg <= 1'b0;
        end else begin
            irq_meta_reg <= i_irq;
            irq_sync_reg <= irq_meta_reg;
            irq_hist_reg <= irq_sync_reg;
        end
    end

    // A wake request counts only once the last two stages agree on high.
    assign irq_wake = irq_sync_reg & irq_hist_reg;

    // Oscillator stop flag; a halt strobe wins over a wake in the same cycle.
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_osc_stop <= 1'b0;
        end else begin
            if (i_halt_op)
                o_osc_stop <= 1'b1;
            else if (irq_wake)
                o_osc_stop <= 1'b0;
        end
    end

    // Low-power wait flag; a wait strobe wins over a wake in the same cycle.
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_wait_state <= 1'b0;
        end else begin
            if (i_wait_for_irq_op)
                o_wait_state <= 1'b1;
            else if (irq_wake)
                o_wait_state <= 1'b0;
        end
    end

endmodule

// >>> hdl/cam_map.vh
// Purpose: Constants for the operand addressing unit.
// Assumes: Included by cam_addr_unit.v and by both bench files.
// Notes:   Mode codes, prefix value, mask levels and zero page top.
`ifndef CAM_MAP_VH
`define CAM_MAP_VH

// Addressing mode codes.
`define CAM_MODE_INH     4'h0
`define CAM_MODE_IMM     4'h1
`define CAM_MODE_DIR_S   4'h2
`define CAM_MODE_DIR_L   4'h3
`define CAM_MODE_IDX_0   4'h4
`define CAM_MODE_IDX_S   4'h5
`define CAM_MODE_IDX_L   4'h6
`define CAM_MODE_IND_S   4'h7
`define CAM_MODE_IND_L   4'h8
`define CAM_MODE_IIX_S   4'h9
`define CAM_MODE_REL     4'hA

// Prefix selecting the second index register.
`define CAM_PFX_SECOND   8'h90
// Interrupt mask levels.
`define CAM_MASK_HIGH    2'h3
`define CAM_MASK_LOW     2'h0
// Zero page top address.
`define CAM_ZP_TOP       16'h00FF

`endif

// >>> tb/cam_addr_unit_checker.sv
// Purpose: Port timing checks for the addressing unit.
// Assumes: Starts arrive only while the unit is idle.
// Notes:   Bound to the unit from the bench top file.
`timescale 1ns/1ps
`include "cam_map.vh"
module cam_addr_unit_checker (
    input wire        i_clk,
    input wire        i_reset,
    input wire        i_start,
    input wire [3:0]  i_mode,
    input wire        i_rmw,
    input wire        i_mask_irq_set_op,
    input wire        i_mask_irq_clear_op,
    input wire        i_halt_op,
    input wire        i_irq,
    input wire [15:0] i_pc,
    input wire        o_mem_rd,
    input wire [15:0] o_mem_addr,
    input wire        o_done,
    input wire        o_illegal,
    input wire [1:0]  o_irq_mask,
    input wire        o_osc_stop
);
    // Every check runs on the core clock and is idle in reset.
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    // A long direct decode starts, then waits three cycles to finish.
    sequence s_long; i_start && i_mode == `CAM_MODE_DIR_L; endsequence
    sequence s_three_quiet; !o_done [*3] ##1 o_done; endsequence
    chk_done_pulse: assert property (o_done |=> !o_done) else $error("done too long");
    chk_inh_len: assert property (
        i_start && i_mode == `CAM_MODE_INH |=> !o_done ##1 o_done) else $error("inh late");
    chk_long_len: assert property (s_long |=> s_three_quiet) else $error("long late");
    chk_long_fetch: assert property (s_long |=> o_mem_rd && o_mem_addr == $past(i_pc) + 16'h0001
        ##1 o_mem_rd && o_mem_addr == $past(i_pc, 2) + 16'h0002) else $error("word fetch");
    chk_indl_len: assert property (
        i_start && i_mode == `CAM_MODE_IND_L |-> ##5 o_done) else $error("ind late");
    chk_rmw_long: assert property (
        i_start && i_rmw && i_mode == `CAM_MODE_DIR_L |-> ##4 o_illegal) else $error("rmw");
    chk_mask_set: assert property (
        i_mask_irq_set_op |=> o_irq_mask == `CAM_MASK_HIGH) else $error("mask set");
    chk_mask_clear: assert property (i_mask_irq_clear_op && !i_mask_irq_set_op
        |=> o_irq_mask == `CAM_MASK_LOW) else $error("mask clear");
    chk_halt_stop: assert property (
        i_halt_op && !i_irq |=> o_osc_stop) else $error("halt");
endmodule

// >>> tb/cam_addr_unit_tb.sv
// Purpose: Self-checking bench for the addressing unit.
// Assumes: Memory answers within the cycle of a read request.
// Notes:   Expected values come from a small model in this file.
`timescale 1ns/1ps
`include "cam_map.vh"
module cam_addr_unit_tb;
    reg         i_clk = 1'b0;
    reg         i_reset = 1'b1;
    reg         i_start = 1'b0;
    reg         i_rmw = 1'b0;
    reg         i_irq = 1'b0;
    reg  [3:0]  ops = 4'h0;
    reg  [3:0]  i_mode = 4'h0;
    reg  [7:0]  i_prefix = 8'h00;
    reg  [7:0]  i_idx_x = 8'h00;
    reg  [7:0]  i_idx_y = 8'h00;
    reg  [7:0]  i_mem_data = 8'h00;
    reg  [15:0] i_pc = 16'h0000;
    reg  [7:0]  tbl [0:255];
    reg  [15:0] exp_q [$];
    wire        o_mem_rd, o_done, o_illegal, o_osc_stop, o_wait_state;
    wire [15:0] o_mem_addr, o_ea, o_pc_next;
    wire [7:0]  o_imm;
    wire [1:0]  o_irq_mask;
    integer     seed = 58810, err_total = 0, cmp_count = 0, cyc = 0, k;

    cam_addr_unit dut (.i_clk, .i_reset, .i_start, .i_prefix, .i_mode, .i_rmw,
        .i_mask_irq_set_op(ops[0]), .i_mask_irq_clear_op(ops[1]), .i_halt_op(ops[2]),
        .i_wait_for_irq_op(ops[3]), .i_irq, .i_pc, .i_idx_x, .i_idx_y, .i_mem_data,
        .o_mem_rd, .o_mem_addr, .o_ea, .o_imm, .o_done, .o_illegal, .o_pc_next,
        .o_irq_mask, .o_osc_stop, .o_wait_state);

    // Clock at 40 MHz.
    always #12.5 i_clk = ~i_clk;

    // Memory content is a random table mixed with the high address byte.
    function [7:0] memf(input [15:0] a);
        memf = tbl[a[7:0]] ^ a[15:8];
    endfunction

    // Memory answers the address requested in the current cycle before its closing edge.
    always @(posedge i_clk) begin
        #2;
        if (o_mem_rd === 1'b1) i_mem_data = memf(o_mem_addr);
    end

    // Cut a hang short.
    always @(posedge i_clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            err_total = err_total + 1;
            close_out;
        end
    end

    task chk(input string nm, input [15:0] seen, input [15:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                err_total = err_total + 1;
                $display("[ERR] %0s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask

    task close_out;
        begin
            $display("compares %0d mismatches %0d", cmp_count, err_total);
            if (err_total == 0 && cmp_count > 0) $display("*** PASS ***");
            else $display("*** FAIL ***");
            $finish;
        end
    endtask

    // One-cycle pulse on an operation strobe, then one idle cycle.
    task strobe(input integer w);
        begin
            ops = 4'h1 << w;
            @(posedge i_clk);
            #2 ops = 4'h0;
            @(posedge i_clk);
            #2;
        end
    endtask

    // One random decode in mode m, checked against the model.
    task run(input [3:0] m);
        integer n, lat, len;
        reg [15:0] ea;
        reg [7:0]  ix, b1, b2, p;
        begin
            i_pc = $random(seed);
            i_idx_x = $random(seed);
            i_idx_y = $random(seed);
            i_prefix = seed[3] ? 8'h90 : $random(seed);
            i_rmw = $random(seed);
            i_mode = m;
            i_start = 1'b1;
            ix = (i_prefix == 8'h90) ? i_idx_y : i_idx_x;
            b1 = memf(i_pc + 16'h0001);
            b2 = memf(i_pc + 16'h0002);
            p = memf({8'h00, b1});
            len = 1;
            lat = 3;
            ea = {8'h00, b1};
            case (m)
                4'h0: begin len = 0; lat = 2; end
                4'h3: begin len = 2; lat = 4; ea = {b1, b2}; end
                4'h4: begin len = 0; lat = 2; ea = {8'h00, ix}; end
                4'h5: ea = {8'h00, b1} + ix;
                4'h6: begin len = 2; lat = 4; ea = {b1, b2} + ix; end
                4'h7: begin lat = 4; ea = {8'h00, p}; end
                4'h8: begin lat = 5; ea = {p, memf({8'h00, b1 + 8'h01})}; end
                4'h9: begin lat = 4; ea = {8'h00, p} + ix; end
                4'hA: ea = i_pc + 16'h0002 + {{8{b1[7]}}, b1};
                default: ;
            endcase
            exp_q.push_back(ea);
            exp_q.push_back(i_pc + 16'h0001 + len[15:0]);
            @(posedge i_clk);
            #2 i_start = 1'b0;
            n = 1;
            while (o_done !== 1'b1 && n < 8) begin
                @(posedge i_clk);
                #2 n = n + 1;
            end
            chk("latency", n[15:0], lat[15:0]);
            ea = exp_q.pop_front();
            chk("pc_next", o_pc_next, exp_q.pop_front());
            if (m > 4'h1) chk("ea", o_ea, ea);
            if (m == 4'h1) chk("imm", {8'h00, o_imm}, {8'h00, b1});
            chk("illegal", {15'h0, o_illegal}, {15'h0, i_rmw && (m == 3 || m == 6 || m == 8)});
        end
    endtask

    // Main sequence: reset, every mode, then mask and power controls.
    initial begin
        for (k = 0; k < 256; k = k + 1) tbl[k] = $random(seed);
        repeat (10) @(posedge i_clk);
        #2 i_reset = 1'b0;
        chk("mask_rst", {14'h0, o_irq_mask}, 16'h0003);
        for (k = 0; k < 11; k = k + 1) repeat (8) run(k[3:0]);
        $display("decode test done");
        strobe(1);
        chk("mask_clr", {14'h0, o_irq_mask}, 16'h0000);
        strobe(0);
        chk("mask_set", {14'h0, o_irq_mask}, 16'h0003);
        strobe(2);
        chk("osc_stop", {15'h0, o_osc_stop}, 16'h0001);
        // The wake request passes a three-stage synchroniser first.
        i_irq = 1'b1;
        repeat (5) @(posedge i_clk);
        #2 chk("osc_wake", {15'h0, o_osc_stop}, 16'h0000);
        i_irq = 1'b0;
        repeat (5) @(posedge i_clk);
        #2 strobe(3);
        chk("wait", {15'h0, o_wait_state}, 16'h0001);
        i_irq = 1'b1;
        repeat (5) @(posedge i_clk);
        #2 chk("wait_wake", {15'h0, o_wait_state}, 16'h0000);
        $display("power test done");
        close_out;
    end
endmodule

bind cam_addr_unit cam_addr_unit_checker u_chk (.i_clk, .i_reset, .i_start, .i_mode, .i_rmw,
    .i_mask_irq_set_op, .i_mask_irq_clear_op, .i_halt_op, .i_irq, .i_pc, .o_mem_rd,
    .o_mem_addr, .o_done, .o_illegal, .o_irq_mask, .o_osc_stop);
